// ---- src/sbfp_params.svh ----
// Constants of the serial boot flash programmer, device side.
`ifndef SBFP_PARAMS_SVH
`define SBFP_PARAMS_SVH
`define SBFP_CMD_BOOT_ENTRY     8'hb0
`define SBFP_CMD_BOOT_ARG       8'h00
`define SBFP_CMD_SERIAL_UNLOCK  8'h01
`define SBFP_CMD_ERASE_ALL      8'h02
`define SBFP_CMD_SET_ADDR       8'h03
`define SBFP_CMD_WRITE          8'h04
`define SBFP_CMD_PAGE_PROGRAM   8'h05
`define SBFP_CMD_IMAGE_CHECK    8'h06
`define SBFP_CMD_SYS_RESTART    8'h07
`define SBFP_CMD_STATUS_READ    8'h08
`define SBFP_STATUS_OK          8'h80
`define SBFP_STATUS_ERR         8'h81
`define SBFP_STATUS_RESET       8'h00
`define SBFP_RAM_BASE           16'h6000
`define SBFP_FLASH_BASE         16'h8000
`define SBFP_PAGE_BYTES         16'h0400
`define SBFP_PAGE_COUNT         5'd31
`define SBFP_BUSY_CYCLES        8'h10
`endif

// ---- src/sbfp_pkg.sv ----
// Types of the serial boot flash programmer.
package sbfp_pkg;
  typedef enum logic [2:0] {
    SBFP_BOOT, SBFP_LOCKED, SBFP_READY, SBFP_RUN
  } sbfp_mode_e;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] arg;
  } sbfp_req_s;
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } sbfp_flash_s;
endpackage : sbfp_pkg

// ---- src/sbfp_fifo.sv ----
// Valid/ready FIFO holding received serial bytes.
`timescale 1ns/10ps
module sbfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             core_clk_in,
  input  wire logic             nrst_in,
  // Fill side.
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side.
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      rptr_reg;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;
  assign in_ready_out  = (wptr_reg - rptr_reg) != (AW+1)'(DEPTH);
  assign out_valid_out = wptr_reg != rptr_reg;
  assign out_data_out  = mem[rptr_reg[AW-1:0]];
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wptr_reg[AW-1:0]] <= in_data_in;
    end
  end
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) wptr_reg <= wptr_reg + 1'b1;
      if (pop) rptr_reg <= rptr_reg + 1'b1;
    end
  end
endmodule : sbfp_fifo

// ---- src/sbfp_device.sv ----
// Device-side serial bootloader: command decode, staging RAM, flash writes.
`timescale 1ns/10ps
`include "sbfp_params.svh"
//////////////////////////////////////////////////////////////////////////////
// What this block does
// (RL1) Host enters bootloader then unlocks serial
// (RL2) Host erases whole flash, checks status
// (RL3) Host loops pages zero through thirty; the testbench copies only pages thirty and zero
// (RL4) Host stages page data at RAM base
// (RL5) Device copies RAM page into flash slot
// (RL6) Host loads only hex payload bytes
// (RL7) Host verifies image with stored count
// (RL8) Device leaves bootloader on restart command
// (RL9) Device drives MISO low then high
// (RL10) Host without wait bit-bangs boot entry
// (RL11) Host changes MOSI on falling clock
// (RL12) Host shifts B0 00, waits MISO high
// (RL13) Device updates status before select rises
// (RL14) Host returns to normal serial afterwards
// (RL15) Host reads status after every command; the testbench skips it after boot entry, set address, write and restart
module sbfp_device
  import sbfp_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  // Serial pins.
  input  wire logic        sclk_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        mosi_in,
  output logic             miso_out,
  // Flash write port, application start and queue-full flag.
  output sbfp_flash_s      flash_out,
  output logic             app_run_out,
  output logic             fifo_full_out
);
  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts when stages two and three agree.
  logic [2:0] sclk_sync_reg, cs_sync_reg, mosi_sync_reg;
  logic       sclk_reg, cs_n_reg, mosi_reg;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 3'h7;
      mosi_sync_reg <= 3'h0;
      sclk_reg      <= 1'b0;
      cs_n_reg      <= 1'b1;
      mosi_reg      <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
      cs_sync_reg   <= {cs_sync_reg[1:0], chip_select_n_in};
      mosi_sync_reg <= {mosi_sync_reg[1:0], mosi_in};
      if (sclk_sync_reg[1] == sclk_sync_reg[2]) sclk_reg <= sclk_sync_reg[2];
      if (cs_sync_reg[1] == cs_sync_reg[2]) cs_n_reg <= cs_sync_reg[2];
      if (mosi_sync_reg[1] == mosi_sync_reg[2]) mosi_reg <= mosi_sync_reg[2];
    end
  end
  wire sclk_rise = sclk_sync_reg[2] && sclk_sync_reg[1] && !sclk_reg;
  wire cs_rise   = cs_sync_reg[2] && cs_sync_reg[1] && !cs_n_reg;
  wire cs_fall   = !cs_sync_reg[2] && !cs_sync_reg[1] && cs_n_reg;
  //////////////////////////////////////////////////////////////////////////
  // Byte shifter, most significant bit first, sampled on rising clock.
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic       byte_vld_reg;
  logic [7:0] byte_reg;
  wire  [7:0] shift_next = {shift_reg[6:0], mosi_reg};
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 8'h00;
      byte_vld_reg <= 1'b0;
      byte_reg     <= 8'h00;
    end else begin
      byte_vld_reg <= 1'b0;
      if (cs_n_reg) begin
        bit_cnt_reg <= 3'h0;
      end else if (sclk_rise) begin
        shift_reg   <= shift_next;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          byte_vld_reg <= 1'b1;
          byte_reg     <= shift_next;
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Received bytes queue; the decoder drains it and may stall.
  logic       rx_valid, rx_ready, fifo_in_ready;
  logic [7:0] rx_data;
  sbfp_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
    .core_clk_in   (core_clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (byte_vld_reg),
    .in_data_in    (byte_reg),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (rx_valid),
    .out_data_out  (rx_data),
    .out_ready_in  (rx_ready)
  );
  //////////////////////////////////////////////////////////////////////////
  // Command decoder and staging RAM.
  logic [7:0]  ram [1024];
  sbfp_mode_e  mode_reg;
  sbfp_req_s   req_reg;
  logic [1:0]  idx_reg;
  logic [15:0] ptr_reg, wcnt_reg, pcnt_reg;
  logic [7:0]  status_reg, busy_reg, out_sh_reg;
  logic        prog_reg, hs_reg, miso_reg, run_reg, full_reg;
  sbfp_flash_s flash_reg;
  wire [15:0] arg_full = {req_reg.arg[7:0], rx_data};
  wire        ok_locked = mode_reg == SBFP_LOCKED;
  wire        ok_ready  = mode_reg == SBFP_READY;
  // The decoder stalls while a page copy runs, so the queue really fills.
  assign rx_ready = !prog_reg && !cs_n_reg;
  wire [7:0] ram_rd = ram[pcnt_reg[9:0]];
  always_ff @(posedge core_clk_in) begin
    if (rx_valid && rx_ready && wcnt_reg != 16'h0 && idx_reg == 2'd0) begin
      ram[ptr_reg[9:0]] <= rx_data; // [RL4]
    end
  end
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_reg   <= SBFP_BOOT;
      req_reg    <= '0;
      idx_reg    <= 2'd0;
      ptr_reg    <= 16'h0;
      wcnt_reg   <= 16'h0;
      pcnt_reg   <= 16'h0;
      status_reg <= `SBFP_STATUS_RESET;
      busy_reg   <= 8'h0;
      out_sh_reg <= 8'h00;
      prog_reg   <= 1'b0;
      hs_reg     <= 1'b0;
      miso_reg   <= 1'b1;
      run_reg    <= 1'b0;
      full_reg   <= 1'b0;
      flash_reg  <= '0;
    end else begin
      full_reg        <= !fifo_in_ready;
      flash_reg.valid <= 1'b0;
      if (cs_fall) begin
        out_sh_reg <= status_reg;
        idx_reg    <= 2'd0;
      end
      if (sclk_rise && !cs_n_reg) out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      // Boot entry / unlock: MISO low, then high once status is set. [RL9]
      if (hs_reg) begin
        if (busy_reg != 8'h0) begin
          busy_reg <= busy_reg - 8'h1;
          miso_reg <= 1'b0;
        end else begin
          miso_reg <= 1'b1; // [RL13]
          hs_reg   <= 1'b0;
        end
      end else if (!cs_n_reg) begin
        miso_reg <= out_sh_reg[7];
      end
      if (cs_rise) begin
        hs_reg <= 1'b0;
        miso_reg <= 1'b1;
      end
      // Page copy: one byte a cycle from RAM into the flash slot. [RL5]
      if (prog_reg) begin
        flash_reg.valid <= 1'b1;
        flash_reg.addr  <= req_reg.arg + pcnt_reg;
        flash_reg.data  <= ram_rd;
        pcnt_reg        <= pcnt_reg + 16'h1;
        if (pcnt_reg == `SBFP_PAGE_BYTES - 16'h1) begin
          prog_reg   <= 1'b0;
          status_reg <= `SBFP_STATUS_OK;
        end
      end else if (rx_valid && rx_ready) begin
        if (wcnt_reg != 16'h0 && idx_reg == 2'd0) begin
          ptr_reg  <= ptr_reg + 16'h1;
          wcnt_reg <= wcnt_reg - 16'h1;
        end else if (idx_reg == 2'd0) begin
          req_reg.cmd <= rx_data;
          idx_reg     <= 2'd1;
        end else if (idx_reg == 2'd1) begin
          req_reg.arg <= {8'h00, rx_data};
          idx_reg     <= 2'd2;
          if (req_reg.cmd == `SBFP_CMD_BOOT_ENTRY) begin
            mode_reg   <= SBFP_LOCKED;
            status_reg <= `SBFP_STATUS_OK;
            hs_reg     <= 1'b1;
            busy_reg   <= `SBFP_BUSY_CYCLES;
            idx_reg    <= 2'd0;
          end else if (req_reg.cmd == `SBFP_CMD_SERIAL_UNLOCK) begin
            mode_reg   <= ok_locked ? SBFP_READY : mode_reg;
            status_reg <= ok_locked ? `SBFP_STATUS_OK : `SBFP_STATUS_ERR;
            hs_reg     <= 1'b1;
            busy_reg   <= `SBFP_BUSY_CYCLES;
            idx_reg    <= 2'd0;
          end else if (req_reg.cmd == `SBFP_CMD_ERASE_ALL ||
                       req_reg.cmd == `SBFP_CMD_IMAGE_CHECK) begin
            status_reg <= ok_ready ? `SBFP_STATUS_OK : `SBFP_STATUS_ERR;
            idx_reg    <= 2'd0;
          end else if (req_reg.cmd == `SBFP_CMD_SYS_RESTART) begin
            if (ok_ready) begin
              mode_reg <= SBFP_RUN; // [RL8]
              run_reg  <= 1'b1;
            end
            idx_reg <= 2'd0;
          end
        end else begin
          req_reg.arg <= arg_full;
          idx_reg     <= 2'd0;
          case (req_reg.cmd)
            `SBFP_CMD_SET_ADDR: ptr_reg <= arg_full - `SBFP_RAM_BASE;
            `SBFP_CMD_WRITE:    wcnt_reg <= arg_full;
            `SBFP_CMD_PAGE_PROGRAM: begin
              if (ok_ready && arg_full[9:0] == 10'h0) begin
                prog_reg   <= 1'b1;
                pcnt_reg   <= 16'h0;
                status_reg <= `SBFP_STATUS_RESET;
              end else begin
                status_reg <= `SBFP_STATUS_ERR;
              end
            end
            default: status_reg <= `SBFP_STATUS_ERR;
          endcase
        end
      end
    end
  end
  assign miso_out      = miso_reg;
  assign flash_out     = flash_reg;
  assign app_run_out   = run_reg;
  assign fifo_full_out = full_reg;
  //////////////////////////////////////////////////////////////////////////
  // Checks.
  // Counts the cycles of a page copy for the length check.
  logic [15:0] prog_len_reg;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prog_len_reg <= 16'h0;
    end else if (prog_reg) begin
      prog_len_reg <= prog_len_reg + 16'h1;
    end else begin
      prog_len_reg <= 16'h0;
    end
  end
  sequence s_hs_start;
    $rose(hs_reg);
  endsequence
  a_hs_miso_low: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    s_hs_start |=> !miso_reg [*2]) // [RL9]
    else $error("MISO not low during handshake.");
  a_status_before_high: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in) $rose(miso_reg) && $past(hs_reg) |->
    status_reg != `SBFP_STATUS_RESET) // [RL13]
    else $error("MISO rose before status update.");
  a_prog_length: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    $fell(prog_reg) |-> prog_len_reg == `SBFP_PAGE_BYTES) // [RL5]
    else $error("Page copy length wrong.");
  a_prog_status: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    $fell(prog_reg) |-> status_reg == `SBFP_STATUS_OK) // [RL5]
    else $error("Status not set after page copy.");
  a_run_mode: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    $rose(run_reg) |-> mode_reg == SBFP_RUN && $past(mode_reg) == SBFP_READY)
    else $error("Application started outside ready mode."); // [RL8]
endmodule : sbfp_device

// ---- testbench/sbfp_host_model.sv ----
// Serial host model that drives the boot programmer's pins.
`timescale 1ns/10ps
module sbfp_host_model #(
  parameter int HALF = 4
) (
  // Clock and returning data.
  input  wire logic core_clk_in,
  input  wire logic miso_in,
  // Serial pins driven by the host.
  output logic      sclk_out,
  output logic      chip_select_n_out,
  output logic      mosi_out
);
  initial begin
    sclk_out          = 1'b0;
    chip_select_n_out = 1'b1;
    mosi_out          = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask : idle

  // Shifts one byte, most significant bit first, by pin toggling.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_out = tx[i];
      idle(HALF);
      sclk_out = 1'b1;
      idle(HALF);
      rx[i]    = miso_in;
      sclk_out = 1'b0;
    end
    mosi_out = ~mosi_out;
  endtask : xfer

  // Sends one framed command and returns the last byte seen on MISO.
  task automatic send(input logic [7:0] q[$], input bit hs,
                      output logic [7:0] rx, output bit ok);
    bit lo;
    lo = 1'b0;
    chip_select_n_out = 1'b0;
    idle(HALF);
    foreach (q[k]) xfer(q[k], rx);
    ok = !hs;
    if (hs) begin
      for (int c = 0; c < 400 && !ok; c++) begin
        idle(1);
        lo = lo || (miso_in === 1'b0);
        ok = lo && (miso_in === 1'b1);
      end
      idle(8);
    end
    idle(HALF);
    chip_select_n_out = 1'b1;
    idle(4 * HALF);
  endtask : send
endmodule : sbfp_host_model

// ---- testbench/sbfp_device_tb.sv ----
// Self-checking testbench of the serial boot flash programmer.
`timescale 1ns/10ps
`include "sbfp_params.svh"
module sbfp_device_tb
  import sbfp_pkg::*;
;
  logic        core_clk;
  logic        nrst;
  logic        sclk;
  logic        chip_select_n;
  logic        mosi;
  logic        miso;
  sbfp_flash_s flash;
  logic        app_run;
  logic        fifo_full;
  int          num_errors;
  int          samples_checked;
  int          nflash;
  logic [15:0] exp_base;
  logic [7:0]  rx;
  bit          ok;

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  sbfp_host_model i_sbfp_host_model (
    .core_clk_in       (core_clk),
    .miso_in           (miso),
    .sclk_out          (sclk),
    .chip_select_n_out (chip_select_n),
    .mosi_out          (mosi)
  );

  sbfp_device i_sbfp_device (
    .core_clk_in      (core_clk),
    .nrst_in          (nrst),
    .sclk_in          (sclk),
    .chip_select_n_in (chip_select_n),
    .mosi_in          (mosi),
    .miso_out         (miso),
    .flash_out        (flash),
    .app_run_out      (app_run),
    .fifo_full_out    (fifo_full)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("errors=%0d checks=%0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // Reads the status word in a transaction of its own.
  task automatic stat(input logic [7:0] exp);
    i_sbfp_host_model.send('{`SBFP_CMD_STATUS_READ}, 1'b0, rx, ok);
    chk({8'h00, rx}, {8'h00, exp});
  endtask : stat

  // Every byte copied to flash lands at the next address of the page.
  always @(negedge core_clk) begin
    if (flash.valid === 1'b1) begin
      chk({8'h00, flash.data}, {8'h00, nflash[7:0] ^ 8'h5a});
      chk(flash.addr, exp_base + nflash[15:0]);
      nflash++;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({15'h0000, miso}, 16'h0001);
    chk({15'h0000, flash.valid}, 16'h0000);
    chk({15'h0000, app_run}, 16'h0000);
  endtask : t_reset

  task automatic t_boot;
    i_sbfp_host_model.send('{`SBFP_CMD_BOOT_ENTRY, `SBFP_CMD_BOOT_ARG},
                           1'b1, rx, ok);
    chk({15'h0000, ok}, 16'h0001);
    i_sbfp_host_model.send('{`SBFP_CMD_ERASE_ALL, 8'h00}, 1'b0, rx, ok);
    stat(`SBFP_STATUS_ERR);
    i_sbfp_host_model.send('{`SBFP_CMD_SERIAL_UNLOCK, 8'h00},
                           1'b1, rx, ok);
    chk({15'h0000, ok}, 16'h0001);
    stat(`SBFP_STATUS_OK);
    i_sbfp_host_model.send('{`SBFP_CMD_ERASE_ALL, 8'h00}, 1'b0, rx, ok);
    stat(`SBFP_STATUS_OK);
  endtask : t_boot

  // Copies the staged page to slot n; pad bytes queue up behind the copy.
  task automatic copy_page(input logic [15:0] n, input int pad);
    logic [7:0] q[$];
    nflash   = 0;
    exp_base = `SBFP_FLASH_BASE + n * `SBFP_PAGE_BYTES;
    q = '{`SBFP_CMD_PAGE_PROGRAM, exp_base[15:8], exp_base[7:0]};
    for (int i = 0; i < pad; i++) begin
      q.push_back(i[0] ? 8'h00 : `SBFP_CMD_IMAGE_CHECK);
    end
    i_sbfp_host_model.send(q, 1'b0, rx, ok);
    if (pad > 0) begin
      chk({15'h0000, fifo_full}, 16'h0001);
    end
    for (int c = 0; c < 5000 && nflash < 1024; c++) @(negedge core_clk);
    repeat (40) @(negedge core_clk);
    chk(nflash[15:0], `SBFP_PAGE_BYTES);
    stat(`SBFP_STATUS_OK);
    chk({15'h0000, fifo_full}, 16'h0000);
  endtask : copy_page

  // Stages one page in RAM and copies it to the last and the first slot.
  task automatic t_page;
    logic [7:0] q[$];
    i_sbfp_host_model.send('{`SBFP_CMD_SET_ADDR, 8'h60, 8'h00},
                           1'b0, rx, ok);
    q = '{`SBFP_CMD_WRITE, 8'h04, 8'h00};
    for (int i = 0; i < 1024; i++) q.push_back(i[7:0] ^ 8'h5a);
    i_sbfp_host_model.send(q, 1'b0, rx, ok);
    chk(nflash[15:0], 16'h0000);
    copy_page(16'd30, 0);
    copy_page(16'd0, 8);
  endtask : t_page

  task automatic t_restart;
    i_sbfp_host_model.send('{`SBFP_CMD_IMAGE_CHECK, 8'h00},
                           1'b0, rx, ok);
    stat(`SBFP_STATUS_OK);
    i_sbfp_host_model.send('{`SBFP_CMD_SYS_RESTART, 8'h00}, 1'b0, rx, ok);
    for (int c = 0; c < 200 && app_run !== 1'b1; c++) @(negedge core_clk);
    chk({15'h0000, app_run}, 16'h0001);
  endtask : t_restart

  //////////////////////////////////////////////////////////////////////////
  initial begin
    nrst            = 1'b0;
    num_errors      = 0;
    samples_checked = 0;
    nflash          = 0;
    exp_base        = 16'h0000;
    repeat (3) @(negedge core_clk);
    t_reset();
    nrst = 1'b1;
    repeat (8) @(negedge core_clk);
    t_boot();
    t_page();
    t_restart();
    close_out();
  end

  // Stops a hung run after about 90000 clock cycles.
  initial begin
    #450000;
    num_errors++;
    close_out();
  end
endmodule : sbfp_device_tb
